/* core/pak_pkg.sv */
// Shared constants of the port A pin block with keyboard pin sharing.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
package pak_pkg;

	// --------------------------------------------------------------------
	// Widths
	// --------------------------------------------------------------------
	localparam int PINS = 8;
	localparam int ADR_W = 10;
	localparam int IDX_W = 8;
	localparam int DAT_W = 32;
	localparam int SEL_W = 4;

	// --------------------------------------------------------------------
	// Register indices; the byte address is four times the index
	// --------------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_OUTPUT_LATCH = 8'h00;
	localparam logic [IDX_W-1:0] IDX_DIRECTION = 8'h04;
	localparam logic [IDX_W-1:0] IDX_KEY_SELECT = 8'h4f;
	localparam int IDX_LSB = 2;

	// --------------------------------------------------------------------
	// Field layout and reset values
	// --------------------------------------------------------------------
	localparam int FIELD_LSB = 0;
	localparam int SEL_LANE = 0;
	localparam logic [PINS-1:0] DIRECTION_RESET = 8'h00;
	localparam logic [PINS-1:0] KEY_SELECT_RESET = 8'h00;
	localparam logic [DAT_W-PINS-1:0] UPPER_ZERO = 24'h000000;

endpackage : pak_pkg

/* core/pak_pin_if.sv */
// Carrier for raw pin levels and their synchronised copies.
// Assumes both ends run on the same bus clock.
`timescale 1ns/1ps
interface pak_pin_if;
	logic [7:0] raw;
	logic [7:0] level;

	modport sync_end (
		input raw,
		output level
	);

	modport user (
		output raw,
		input level
	);
endinterface : pak_pin_if

/* core/pak_pin_sync.sv */
// Two-stage synchroniser for the eight pin input levels.
// Assumes the raw levels are asynchronous to clk_i.
`timescale 1ns/1ps
module pak_pin_sync (
	input wire logic clk_i,
	pak_pin_if.sync_end pins
);
	import pak_pkg::*;

	// --------------------------------------------------------------------
	// Per-pin synchroniser chains
	// --------------------------------------------------------------------
	// The first stage feeds only the second stage.
	genvar g;
	generate
		for (g = 0; g < PINS; g++) begin : g_sync
			logic meta_r;
			logic level_r;
			always_ff @(posedge clk_i) begin
				meta_r <= pins.raw[g];
				level_r <= meta_r;
			end
			assign pins.level[g] = level_r;
		end
	endgenerate

endmodule : pak_pin_sync

/* core/pak_port.sv */
// Port A pin block: output latch, direction and keyboard pin select.
// Assumes a classic Wishbone master and board logic resolving the pins.
`timescale 1ns/1ps

// How it works
// - Eight pins, one latch bit each, one byte.
// - Latch readable, writable, untouched by reset.
// - Direction one drives pin; zero floats it.
// - Direction readable, writable, cleared by reset.
// - Input pins read back the synchronised level.
// - Latch writes always land, whatever direction.
// - Key select bit hands pin to keyboard.
// - Reset clears every key select bit.
// - Key select register, bit n for pin n.
module pak_port (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [pak_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [pak_pkg::SEL_W-1:0] wb_sel_i,
	input wire logic [pak_pkg::DAT_W-1:0] wb_dat_i,
	output logic [pak_pkg::DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [pak_pkg::PINS-1:0] pin_in_i,
	output logic [pak_pkg::PINS-1:0] pin_out_o,
	output logic [pak_pkg::PINS-1:0] pin_oe_n_o,
	output logic [pak_pkg::PINS-1:0] key_irq_pin_select_o,
	output logic [pak_pkg::PINS-1:0] keypad_wake_input_o
);
	import pak_pkg::*;

	// --------------------------------------------------------------------
	// Decode helper
	// --------------------------------------------------------------------
	function automatic logic hits(input logic [ADR_W-1:0] adr,
		input logic [IDX_W-1:0] idx);
		hits = (adr[IDX_LSB +: IDX_W] == idx) &&
			(adr[IDX_LSB-1:0] == 2'h0);
	endfunction : hits

	// --------------------------------------------------------------------
	// State
	// --------------------------------------------------------------------
	logic [PINS-1:0] latch_r;
	logic [PINS-1:0] latch_nxt;
	logic [PINS-1:0] dir_r;
	logic [PINS-1:0] dir_nxt;
	logic [PINS-1:0] ksel_r;
	logic [PINS-1:0] ksel_nxt;
	logic [PINS-1:0] oe_n_r;
	logic [PINS-1:0] oe_n_nxt;
	logic [PINS-1:0] wake_r;
	logic [PINS-1:0] wake_nxt;
	logic ack_r;
	logic ack_nxt;
	logic [DAT_W-1:0] rdat_r;
	logic [DAT_W-1:0] rdat_nxt;

	// --------------------------------------------------------------------
	// Pin synchroniser
	// --------------------------------------------------------------------
	pak_pin_if pin_bus ();
	assign pin_bus.raw = pin_in_i;

	pak_pin_sync u_sync (
		.clk_i(clk_i),
		.pins(pin_bus.sync_end)
	);

	wire [PINS-1:0] level = pin_bus.level;

	// --------------------------------------------------------------------
	// Bus decode
	// --------------------------------------------------------------------
	wire req = wb_cyc_i && wb_stb_i;
	wire lane0 = wb_sel_i[SEL_LANE];
	wire hit_latch = hits(wb_adr_i, IDX_OUTPUT_LATCH);
	wire hit_dir = hits(wb_adr_i, IDX_DIRECTION);
	wire hit_ksel = hits(wb_adr_i, IDX_KEY_SELECT);
	// A write lands on the edge where the master samples the acknowledge.
	wire wr_fire = req && ack_r && wb_we_i && lane0 && !rst_i;
	wire [PINS-1:0] wdat = wb_dat_i[FIELD_LSB +: PINS];

	// Output pins read the latch, input pins read the pin level.
	wire [PINS-1:0] port_view = (dir_r & latch_r) |
		(~dir_r & level);
	wire [PINS-1:0] rd_field = hit_latch ? port_view :
		hit_dir ? dir_r :
		hit_ksel ? ksel_r : 8'h00;

	// --------------------------------------------------------------------
	// Next-state logic
	// --------------------------------------------------------------------
	assign ack_nxt = rst_i ? 1'b0 : (req && !ack_r);
	assign rdat_nxt = (req && !ack_r) ? {UPPER_ZERO, rd_field} : rdat_r;
	// The latch always takes a write, even for an input pin.
	assign latch_nxt = (wr_fire && hit_latch) ? wdat : latch_r;
	assign dir_nxt = rst_i ? DIRECTION_RESET :
		((wr_fire && hit_dir) ? wdat : dir_r);
	assign ksel_nxt = rst_i ? KEY_SELECT_RESET :
		((wr_fire && hit_ksel) ? wdat : ksel_r);
	// A pin handed to the keyboard function is an input only.
	assign oe_n_nxt = ~(dir_nxt & ~ksel_nxt);
	assign wake_nxt = rst_i ? 8'h00 : (level & ksel_r);

	// --------------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------------
	// The latch has no reset on purpose.
	always_ff @(posedge clk_i) begin
		latch_r <= latch_nxt;
	end

	always_ff @(posedge clk_i) begin
		dir_r <= dir_nxt;
		ksel_r <= ksel_nxt;
		oe_n_r <= oe_n_nxt;
		wake_r <= wake_nxt;
		ack_r <= ack_nxt;
		rdat_r <= rdat_nxt;
	end

	// --------------------------------------------------------------------
	// Outputs
	// --------------------------------------------------------------------
	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;
	assign pin_out_o = latch_r;
	assign pin_oe_n_o = oe_n_r;
	assign key_irq_pin_select_o = ksel_r;
	assign keypad_wake_input_o = wake_r;

	// --------------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_dir_reset_clear: assert property (
		@(posedge clk_i) disable iff (1'b0) rst_i |=> dir_r == 8'h00)
		else $error("direction not cleared by reset");

	a_key_reset_clear: assert property (
		@(posedge clk_i) disable iff (1'b0) rst_i |=> ksel_r == 8'h00)
		else $error("key select not cleared by reset");

	a_latch_keep_reset: assert property (
		@(posedge clk_i) disable iff (1'b0) rst_i |=> $stable(latch_r))
		else $error("latch changed under reset");

	a_oe_from_dir: assert property (
		$past(wr_fire) && $past(hit_dir) && !$past(ksel_r[0]) |->
			oe_n_r[0] == !$past(wdat[0]))
		else $error("output enable does not follow direction");

	a_read_port_mix: assert property (
		req && !ack_r && !wb_we_i && hit_latch |=>
			wb_ack_o && wb_dat_o[7:0] == (($past(dir_r) & $past(latch_r))
			| (~$past(dir_r) & $past(level))))
		else $error("port read mixes wrong sources");

	a_write_latch_any: assert property (
		wr_fire && hit_latch |=> latch_r == $past(wdat))
		else $error("latch write lost");

	a_sync_two_stage: assert property (
		##2 level == $past(pin_in_i, 2))
		else $error("pin level not two flops behind");

	a_wake_masked: assert property (
		##1 keypad_wake_input_o == ($past(level) & $past(ksel_r)))
		else $error("keyboard pin level wrong");

	a_ack_one_cycle: assert property (
		req && !ack_r |=> ack_r ##1 !ack_r)
		else $error("acknowledge not a single cycle");

	c_read_input: cover property (req && ack_r && !wb_we_i && hit_latch
		&& dir_r != 8'hff);
	c_write_dir: cover property (wr_fire && hit_dir && wdat != 8'h00);
	c_key_select: cover property (wr_fire && hit_ksel);

endmodule : pak_port

/* verification/pak_pin_model.sv */
// Board model for the port A pins.
// Assumes active-low output enables; the board drives floating pins.
`timescale 1ns/1ps
module pak_pin_model (
	input wire logic [7:0] drv_i,
	input wire logic [7:0] oe_n_i,
	input wire logic [7:0] ext_i,
	output logic [7:0] pin_o
);
	// A pin driven by the port shows the latch; a floating pin shows the board.
	assign pin_o = (drv_i & ~oe_n_i) | (ext_i & oe_n_i);
endmodule : pak_pin_model

/* verification/port_a_gpio_keyboard_share_bench.sv */
// Self-checking bench for the port A pin block.
// Assumes the pin model stands between the port outputs and pin inputs.
`timescale 1ns/1ps
module port_a_gpio_keyboard_share_bench;
	import pak_pkg::*;
	localparam logic [9:0] A_LAT = {IDX_OUTPUT_LATCH, 2'b00};
	localparam logic [9:0] A_DIR = {IDX_DIRECTION, 2'b00};
	localparam logic [9:0] A_KEY = {IDX_KEY_SELECT, 2'b00};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [9:0] adr = 10'h000;
	logic [31:0] dat = 32'h00000000;
	logic [7:0] ext = 8'h00;
	logic [7:0] rd;
	logic [31:0] dat_o;
	logic ack;
	logic [7:0] pin_in, pin_out, oe_n, key_sel, wake;
	int mismatches = 0;
	int checks_done = 0;
	always #12.5 clk_i = ~clk_i;
	pak_port u_pak_port (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1),
		.wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_n_o(oe_n),
		.key_irq_pin_select_o(key_sel), .keypad_wake_input_o(wake));
	pak_pin_model u_pak_pin_model (.drv_i(pin_out), .oe_n_i(oe_n),
		.ext_i(ext), .pin_o(pin_in));
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [9:0] a,
		input logic [7:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h000000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rd = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) begin
			mismatches++;
			stop_test();
		end
		@(posedge clk_i);
	endtask : bus
	task automatic t_reset;
		chk("oe_n", 8'hff, oe_n);
		bus(1'b0, A_DIR, 8'h00);
		chk("dir", 8'h00, rd);
		bus(1'b0, A_KEY, 8'h00);
		chk("key", 8'h00, rd);
		bus(1'b0, 10'h020, 8'h00);
		chk("unmapped", 8'h00, rd);
		$display("test reset done");
	endtask : t_reset
	task automatic t_inout;
		ext <= 8'h3c;
		bus(1'b1, A_LAT, 8'ha5);
		repeat (4) @(posedge clk_i);
		bus(1'b0, A_LAT, 8'h00);
		chk("in read", 8'h3c, rd);
		chk("pin_out", 8'ha5, pin_out);
		bus(1'b1, A_DIR, 8'h0f);
		bus(1'b0, A_LAT, 8'h00);
		chk("mixed", 8'h35, rd);
		chk("oe_n", 8'hf0, oe_n);
		bus(1'b1, A_DIR, 8'hff);
		bus(1'b0, A_DIR, 8'h00);
		chk("dir", 8'hff, rd);
		bus(1'b0, A_LAT, 8'h00);
		chk("latch", 8'ha5, rd);
		$display("test inout done");
	endtask : t_inout
	task automatic t_key;
		bus(1'b1, A_KEY, 8'h5a);
		bus(1'b0, A_KEY, 8'h00);
		chk("key rd", 8'h5a, rd);
		chk("key out", 8'h5a, key_sel);
		chk("oe_n", 8'h5a, oe_n);
		repeat (4) @(posedge clk_i);
		chk("wake", 8'h18, wake);
		bus(1'b1, A_KEY, 8'h00);
		chk("oe_n", 8'h00, oe_n);
		$display("test key done");
	endtask : t_key
	task automatic t_rereset;
		bus(1'b1, A_KEY, 8'h81);
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("pin_out", 8'ha5, pin_out);
		bus(1'b0, A_DIR, 8'h00);
		chk("dir", 8'h00, rd);
		bus(1'b0, A_KEY, 8'h00);
		chk("key", 8'h00, rd);
		$display("test rereset done");
	endtask : t_rereset
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset();
		t_inout();
		t_key();
		t_rereset();
		stop_test();
	end
endmodule : port_a_gpio_keyboard_share_bench
